// *** src/can_bt_regs.svh ***
// bit-timing register map, field positions, reset values and fixed counts
// assumes: included by the bit-timing core; definitions only
`ifndef CAN_BT_REGS_SVH
`define CAN_BT_REGS_SVH

`define PRESCALE_JUMP_WIDTH_ADDR    8'h2a
`define SEGMENT_SAMPLING_SETUP_ADDR 8'h29
`define PRESCALE_JUMP_WIDTH_RST     8'h00
`define SEGMENT_SAMPLING_SETUP_RST  8'h00

`define JUMP_WIDTH_MSB        7
`define JUMP_WIDTH_LSB        6
`define QUANTUM_PRESCALER_MSB 5
`define QUANTUM_PRESCALER_LSB 0
`define SEG2_LENGTH_MODE_BIT  7
`define TRIPLE_SAMPLE_SEL_BIT 6
`define PHASE_ONE_MSB         5
`define PHASE_ONE_LSB         3
`define PROPAGATION_MSB       2
`define PROPAGATION_LSB       0

// quanta of information processing time after the sample point
`define PROCESSING_TIME_TQ 4'h2
`define ONE_TQ             4'h1
`define READ_DATA_RST      8'h00
`define TQ_CNT_RST         7'h00

`endif

// *** src/can_bt_pkg.sv ***
// types shared by the bit-timing core and its bench
// assumes: compiled before the core
package can_bt_pkg;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    SEG_SYNC  = 2'b00,
    SEG_PROP  = 2'b01,
    SEG_PH1   = 2'b10,
    SEG_PH2   = 2'b11
  } seg_t;
endpackage

// *** src/can_bit_timing_config.sv ***
// bit-timing configuration registers and the nominal bit timer they steer
// assumes: register requests come from the serial command engine, one per cycle,
// rx_in and bus_idle_in are already synchronous to ref_clk_in (oscillator input)
// Contract
// - with the phase-two mode bit set, phase segment 2 lasts the separate phase-two length field plus one quantum.
// - with the phase-two mode bit clear, phase segment 2 is the larger of phase segment 1 and 2 quanta.
// - with the sampling bit set, the bus is sampled three times, the last of them at the sample point.
// - with the sampling bit clear, the bus is sampled once at the sample point.
// - phase segment 1 lasts its 3-bit field plus one quanta.
// - the propagation segment lasts its 3-bit field plus one quanta.
// - one quantum is 2 x (prescaler + 1) oscillator cycles.
// - resynchronisation lengthens or shortens by at most the jump width of 1 to 4 quanta.
// - triple sampling takes two extra samples half a quantum apart and uses the majority.
// - the timing registers accept writes only in configuration mode.
`timescale 1ns/10ps
`default_nettype none
`include "can_bt_regs.svh"

module can_bit_timing_config
  import can_bt_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rstn_in,
  input  wire reg_req_t   reg_req_in,
  input  wire logic       config_mode_in,
  input  wire logic [2:0] phase_two_length_in,
  input  wire logic       rx_in,
  input  wire logic       bus_idle_in,
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out,
  output logic            tq_tick_out,
  output logic            sample_point_out,
  output logic            rx_bit_out
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic maj3(input logic a, input logic b, input logic c);
    maj3 = (a & b) | (a & c) | (b & c);
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pjw_q, pjw_d;
  logic [7:0] sss_q, sss_d;
  logic [7:0] rdat_q, rdat_d;
  logic       rval_q, rval_d;
  always_comb begin
    pjw_d  = pjw_q;
    sss_d  = sss_q;
    rdat_d = rdat_q;
    rval_d = reg_req_in.rd;
    if (reg_req_in.wr && config_mode_in) begin
      if (reg_req_in.addr == `PRESCALE_JUMP_WIDTH_ADDR) pjw_d = reg_req_in.wdata;
      if (reg_req_in.addr == `SEGMENT_SAMPLING_SETUP_ADDR) sss_d = reg_req_in.wdata;
    end
    if (reg_req_in.rd) begin
      unique case (reg_req_in.addr)
        `PRESCALE_JUMP_WIDTH_ADDR:    rdat_d = pjw_q;
        `SEGMENT_SAMPLING_SETUP_ADDR: rdat_d = sss_q;
        default:                      rdat_d = `READ_DATA_RST;
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pjw_q  <= `PRESCALE_JUMP_WIDTH_RST;
      sss_q  <= `SEGMENT_SAMPLING_SETUP_RST;
      rdat_q <= `READ_DATA_RST;
      rval_q <= 1'b0;
    end else begin
      pjw_q  <= pjw_d;
      sss_q  <= sss_d;
      rdat_q <= rdat_d;
      rval_q <= rval_d;
    end
  end

  // ----------------------------------------------------------------
  // decoded lengths
  // ----------------------------------------------------------------
  logic [5:0] quantum_prescaler;
  logic [3:0] sjw_len, prop_len, ph1_len, ph2_len;
  logic       seg2_length_mode, triple_sample_sel;
  always_comb begin
    quantum_prescaler = pjw_q[`QUANTUM_PRESCALER_MSB:`QUANTUM_PRESCALER_LSB];
    sjw_len  = {2'b00, pjw_q[`JUMP_WIDTH_MSB:`JUMP_WIDTH_LSB]} + `ONE_TQ;
    prop_len = {1'b0, sss_q[`PROPAGATION_MSB:`PROPAGATION_LSB]} + `ONE_TQ;
    ph1_len  = {1'b0, sss_q[`PHASE_ONE_MSB:`PHASE_ONE_LSB]} + `ONE_TQ;
    seg2_length_mode  = sss_q[`SEG2_LENGTH_MODE_BIT];
    triple_sample_sel = sss_q[`TRIPLE_SAMPLE_SEL_BIT];
    ph2_len = seg2_length_mode ? {1'b0, phase_two_length_in} + `ONE_TQ
            : (ph1_len > `PROCESSING_TIME_TQ) ? ph1_len : `PROCESSING_TIME_TQ;
  end

  // ----------------------------------------------------------------
  // bit timer
  // ----------------------------------------------------------------
  logic [6:0] tq_cnt_q, tq_cnt_d;
  seg_t       seg_q, seg_d;
  logic [3:0] q_q, q_d;
  logic [4:0] e_q, e_d;
  logic [3:0] ext_q, ext_d;
  logic [3:0] shr_q, shr_d;
  logic       synced_q, synced_d;
  logic       rx_prev_q;
  logic [1:0] hist_q, hist_d;
  logic       bit_q, bit_d;
  logic       sp_q, sp_d;
  logic       tick_q;
  logic       tq_end, half_tick, edge_seen, restart, last_ph1;
  logic [3:0] rem;
  always_comb begin
    tq_end    = (tq_cnt_q == {quantum_prescaler, 1'b1});
    half_tick = tq_end || (tq_cnt_q == {1'b0, quantum_prescaler});
    edge_seen = rx_prev_q && !rx_in && !synced_q && bit_q;
    rem       = ph2_len - q_q;
    last_ph1  = (seg_q == SEG_PH1) && (q_q == ph1_len + ext_q - `ONE_TQ);
    tq_cnt_d  = tq_end ? `TQ_CNT_RST : tq_cnt_q + 7'h01;
    seg_d     = seg_q;
    q_d       = q_q;
    e_d       = e_q;
    ext_d     = ext_q;
    shr_d     = shr_q;
    synced_d  = synced_q;
    hist_d    = half_tick ? {hist_q[0], rx_in} : hist_q;
    bit_d     = bit_q;
    sp_d      = 1'b0;
    restart   = 1'b0;
    if (edge_seen) begin
      synced_d = 1'b1;
      if (bus_idle_in) begin
        restart = 1'b1;
      end else begin
        unique case (seg_q)
          SEG_SYNC: ;
          SEG_PROP, SEG_PH1: begin
            if (e_q <= {1'b0, sjw_len}) restart = 1'b1;
            else ext_d = sjw_len;
          end
          SEG_PH2: begin
            if (rem <= sjw_len) restart = 1'b1;
            else shr_d = sjw_len;
          end
        endcase
      end
    end
    if (restart) begin
      tq_cnt_d = `TQ_CNT_RST;
      seg_d    = SEG_SYNC;
      q_d      = 4'h0;
      e_d      = 5'h00;
      ext_d    = 4'h0;
      shr_d    = 4'h0;
    end else if (tq_end) begin
      q_d = q_q + 4'h1;
      e_d = e_q + 5'h01;
      unique case (seg_q)
        SEG_SYNC: begin
          seg_d    = SEG_PROP;
          q_d      = 4'h0;
          e_d      = 5'h01;
          synced_d = 1'b0;
        end
        SEG_PROP: begin
          if (q_q == prop_len - `ONE_TQ) begin
            seg_d = SEG_PH1;
            q_d   = 4'h0;
          end
        end
        SEG_PH1: begin
          if (last_ph1) begin
            seg_d = SEG_PH2;
            q_d   = 4'h0;
            sp_d  = 1'b1;
            bit_d = triple_sample_sel ? maj3(hist_q[1], hist_q[0], rx_in) : rx_in;
          end
        end
        SEG_PH2: begin
          // at or past the end: a shortening seen on a quantum edge must not be missed
          if (q_q >= ph2_len - shr_q - `ONE_TQ) begin
            seg_d = SEG_SYNC;
            q_d   = 4'h0;
            ext_d = 4'h0;
            shr_d = 4'h0;
          end
        end
      endcase
    end
  end
  always_ff @(posedge ref_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      tq_cnt_q  <= `TQ_CNT_RST;
      seg_q     <= SEG_SYNC;
      q_q       <= 4'h0;
      e_q       <= 5'h00;
      ext_q     <= 4'h0;
      shr_q     <= 4'h0;
      synced_q  <= 1'b0;
      rx_prev_q <= 1'b1;
      hist_q    <= 2'b11;
      bit_q     <= 1'b1;
      sp_q      <= 1'b0;
      tick_q    <= 1'b0;
    end else begin
      tq_cnt_q  <= tq_cnt_d;
      seg_q     <= seg_d;
      q_q       <= q_d;
      e_q       <= e_d;
      ext_q     <= ext_d;
      shr_q     <= shr_d;
      synced_q  <= synced_d;
      rx_prev_q <= rx_in;
      hist_q    <= hist_d;
      bit_q     <= bit_d;
      sp_q      <= sp_d;
      tick_q    <= tq_end;
    end
  end

  assign rd_data_out      = rdat_q;
  assign rd_valid_out     = rval_q;
  assign tq_tick_out      = tick_q;
  assign sample_point_out = sp_q;
  assign rx_bit_out       = bit_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  property p_write_locked;
    reg_req_in.wr && !config_mode_in |=> $stable(pjw_q) && $stable(sss_q);
  endproperty
  a_write_locked: assert property (p_write_locked) else $error("write outside config mode");
  property p_ph2_field;
    seg2_length_mode |-> ph2_len == {1'b0, phase_two_length_in} + `ONE_TQ;
  endproperty
  a_ph2_field: assert property (p_ph2_field) else $error("phase two not from field");
  property p_ph2_auto;
    !seg2_length_mode |-> ph2_len >= `PROCESSING_TIME_TQ && ph2_len >= ph1_len;
  endproperty
  a_ph2_auto: assert property (p_ph2_auto) else $error("phase two too short");
  property p_single;
    sp_q && !$past(triple_sample_sel) |-> bit_q == $past(rx_in);
  endproperty
  a_single: assert property (p_single) else $error("single sample wrong");
  property p_triple;
    sp_q && $past(triple_sample_sel) |->
      bit_q == maj3($past(hist_q[1]), $past(hist_q[0]), $past(rx_in));
  endproperty
  a_triple: assert property (p_triple) else $error("majority sample wrong");
  property p_ph1_end;
    sp_q |-> $past(q_q) == $past(ph1_len) + $past(ext_q) - `ONE_TQ;
  endproperty
  a_ph1_end: assert property (p_ph1_end) else $error("phase one length wrong");
  property p_prop_end;
    seg_q == SEG_PROP && tq_end && !restart && q_q == prop_len - `ONE_TQ
      |=> seg_q == SEG_PH1;
  endproperty
  a_prop_end: assert property (p_prop_end) else $error("propagation length wrong");
  // a restart right after the wrap holds the count at zero one more cycle
  property p_tq_wrap;
    tq_end ##1 !restart |=> tq_cnt_q == 7'h01;
  endproperty
  a_tq_wrap: assert property (p_tq_wrap) else $error("quantum length wrong");
  property p_sjw_bound;
    ext_q <= sjw_len && shr_q <= sjw_len;
  endproperty
  a_sjw_bound: assert property (p_sjw_bound) else $error("jump width exceeded");
  property p_sjw_decode;
    pjw_q[`JUMP_WIDTH_MSB:`JUMP_WIDTH_LSB] == 2'b11 |-> sjw_len == 4'h4;
  endproperty
  a_sjw_decode: assert property (p_sjw_decode) else $error("jump width decode wrong");
  property p_cov_triple;
    sp_q && triple_sample_sel;
  endproperty
  c_cov_triple: cover property (p_cov_triple);
  property p_cov_hard;
    edge_seen && bus_idle_in;
  endproperty
  c_cov_hard: cover property (p_cov_hard);
  property p_cov_lengthen;
    edge_seen && !restart && seg_q == SEG_PH1;
  endproperty
  c_cov_lengthen: cover property (p_cov_lengthen);

endmodule

`default_nettype wire

// *** tb/can_node_model.sv ***
// far-side bus node: drives the received line and the bus-idle flag
// assumes: driven from the bench by drive_level at rising clock edges
`timescale 1ns/10ps
`default_nettype none

module can_node_model (
  input  wire logic clk_in,
  output logic      rx_out,
  output logic      idle_out
);
  // recessive and idle until a frame starts
  initial begin
    rx_out   = 1'b1;
    idle_out = 1'b1;
  end

  task automatic drive_level(input logic level, input logic idle);
    @(posedge clk_in);
    rx_out   <= level;
    idle_out <= idle;
  endtask
endmodule

`default_nettype wire

// *** tb/can_bit_timing_config_test.sv ***
// self-checking bench for the bit-timing configuration block
// assumes: design package and register header compiled and on the include path
`timescale 1ns/10ps
`default_nettype none
`include "can_bt_regs.svh"

module can_bit_timing_config_test;
  import can_bt_pkg::*;

  logic       ref_clk_in = 1'b0;
  logic       rstn_in    = 1'b0;
  reg_req_t   req        = '0;
  logic       cfg_mode   = 1'b1;
  logic [2:0] ph2_field  = 3'h0;
  logic       rx;
  logic       idle;
  logic [7:0] rd_data;
  logic       rd_valid;
  logic       tq_tick;
  logic       sample_pt;
  logic       rx_bit;
  int         err_count  = 0;
  int         cmp_count  = 0;
  int         cycles     = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  can_bit_timing_config can_bit_timing_config_inst (
    .ref_clk_in          (ref_clk_in),
    .rstn_in             (rstn_in),
    .reg_req_in          (req),
    .config_mode_in      (cfg_mode),
    .phase_two_length_in (ph2_field),
    .rx_in               (rx),
    .bus_idle_in         (idle),
    .rd_data_out         (rd_data),
    .rd_valid_out        (rd_valid),
    .tq_tick_out         (tq_tick),
    .sample_point_out    (sample_pt),
    .rx_bit_out          (rx_bit)
  );

  can_node_model can_node_model_inst (
    .clk_in   (ref_clk_in),
    .rx_out   (rx),
    .idle_out (idle)
  );

  // ----------------------------------------
  // checks and closing
  // ----------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  // ----------------------------------------
  // register access
  // ----------------------------------------
  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    @(posedge ref_clk_in);
    req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge ref_clk_in);
    req <= '0;
  endtask

  task automatic reg_read_check(input string name, input logic [7:0] addr,
                                input logic [7:0] exp);
    @(posedge ref_clk_in);
    req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
    @(posedge ref_clk_in);
    req <= '0;
    // valid stands only in the cycle after the read edge
    #1;
    check({name, " valid"}, {15'h0000, rd_valid}, 16'h0001);
    check(name, {8'h00, rd_data}, {8'h00, exp});
    @(posedge ref_clk_in);
  endtask

  // ----------------------------------------
  // bit timer measurement
  // ----------------------------------------
  task automatic wait_sample(output int n);
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (sample_pt !== 1'b1 && n < 2000);
  endtask

  task automatic wait_tick(output int n);
    n = 0;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (tq_tick !== 1'b1 && n < 2000);
  endtask

  function automatic logic [15:0] bit_cycles(input logic [7:0] c1, input logic [7:0] c2,
                                             input logic [2:0] f);
    int ph1;
    int ph2;
    ph1 = c2[5:3] + 1;
    ph2 = c2[7] ? f + 1 : (ph1 > 2 ? ph1 : 2);
    return 16'((1 + c2[2:0] + 1 + ph1 + ph2) * 2 * (c1[5:0] + 1));
  endfunction

  logic [7:0] c1_tab [5] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h03};
  logic [7:0] c2_tab [5] = '{8'h00, 8'h1a, 8'h81, 8'h08, 8'h80};
  logic [2:0] f_tab  [5] = '{3'h0, 3'h7, 3'h5, 3'h6, 3'h0};

  initial begin
    int n;
    repeat (6) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    reg_read_check("jump width reset", `PRESCALE_JUMP_WIDTH_ADDR, 8'h00);
    reg_read_check("segment reset", `SEGMENT_SAMPLING_SETUP_ADDR, 8'h00);
    reg_read_check("unmapped read", 8'h30, 8'h00);
    reg_write(`PRESCALE_JUMP_WIDTH_ADDR, 8'hc5);
    reg_read_check("jump width rw", `PRESCALE_JUMP_WIDTH_ADDR, 8'hc5);
    cfg_mode <= 1'b0;
    reg_write(`PRESCALE_JUMP_WIDTH_ADDR, 8'h3f);
    reg_write(`SEGMENT_SAMPLING_SETUP_ADDR, 8'hff);
    reg_read_check("locked prescaler", `PRESCALE_JUMP_WIDTH_ADDR, 8'hc5);
    reg_read_check("locked segment", `SEGMENT_SAMPLING_SETUP_ADDR, 8'h00);
    cfg_mode <= 1'b1;
    // bit length across prescaler, segment and phase-two modes
    foreach (c1_tab[i]) begin
      reg_write(`PRESCALE_JUMP_WIDTH_ADDR, c1_tab[i]);
      reg_write(`SEGMENT_SAMPLING_SETUP_ADDR, c2_tab[i]);
      ph2_field <= f_tab[i];
      wait_sample(n);
      wait_sample(n);
      wait_sample(n);
      check("bit period", 16'(n), bit_cycles(c1_tab[i], c2_tab[i], f_tab[i]));
      wait_tick(n);
      wait_tick(n);
      check("quantum", 16'(n), 16'(2 * (c1_tab[i][5:0] + 1)));
    end
    // received bit in single and triple sampling; first edge hard-syncs on an idle bus
    for (int m = 0; m < 2; m++) begin
      reg_write(`SEGMENT_SAMPLING_SETUP_ADDR, m ? 8'h5b : 8'h1b);
      can_node_model_inst.drive_level(1'b0, m == 0);
      wait_sample(n);
      wait_sample(n);
      #1;
      check("dominant bit", {15'h0000, rx_bit}, 16'h0000);
      can_node_model_inst.drive_level(1'b1, 1'b0);
      wait_sample(n);
      wait_sample(n);
      #1;
      check("recessive bit", {15'h0000, rx_bit}, 16'h0001);
      // dominant only in the sample clock: single sampling takes it, majority rejects it
      repeat (bit_cycles(8'h03, m ? 8'h5b : 8'h1b, 3'h0) - 16'h0003) @(posedge ref_clk_in);
      can_node_model_inst.drive_level(1'b0, 1'b0);
      can_node_model_inst.drive_level(1'b1, 1'b0);
      wait_sample(n);
      #1;
      check("short dominant", {15'h0000, rx_bit}, {15'h0000, m[0]});
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
